// *** verilog/aal1_seg_defs.vh ***
// field positions, reset values and counts for the cbr cell segmenter
`ifndef AAL1_SEG_DEFS_VH
`define AAL1_SEG_DEFS_VH

// per-vc state word
`define ST_W        119
`define OCT_P       0
`define NCH_P       6
`define RM_P        14
`define RDP_P       15
`define WMF_P       22
`define FST_P       23
`define SRTS_P      24
`define SN_P        28
`define SE_P        31
`define PS_P        32
`define PE_P        33
`define PN_P        34
`define MODE_P      35
`define SBP_P       37
`define SLEN_P      49
`define CTDM_P      61
`define CCAS_P      69
`define LAST_P      77
`define NCAS_P      85
`define CNT_P       92
`define BIDX_P      108

// header word, byte 0 in the top bits
`define HDR_W       48
`define GFC_P       44
`define VPI_P       36
`define VCI_P       20
`define PTI_P       17
`define CLP_P       16
`define HEC_P       8
`define UDF2_P      0

// configuration selects
`define SEL_HDR     2'h0
`define SEL_ST      2'h1
`define SEL_BASE    2'h2

// counts and initial values
`define PAYLOAD_LEN 6'h2F
`define CBUF_FIRST  8'h0A
`define LAST_HDR8   3'h4
`define LAST_HDR16  3'h5
`define NO_BOUNDARY 7'h7F
`define PTR_MAX     12'h05D
`define NUM_VC      256
`define NUM_BASE    2048
`define NUM_PORT    8
`define FIFO_DEPTH  8
`define FIFO_WIDTH  9

`endif

// *** verilog/seg_byte_fifo.v ***
// small synchronous fifo between the segmenter and the cell transmit port
`timescale 1ns/1ps
module seg_byte_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clock_i,
    input  wire             sys_rst_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      cnt_reg;
    wire            push;
    wire            pop;

    assign in_ready_o  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always @(posedge clock_i) begin
        if (push) begin
            mem[wr_reg] <= in_data_i;
        end
    end

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // seg_byte_fifo

// *** verilog/aal1_cbr_cell_segmenter.v ***
// aal1 cbr cell segmentation engine for unstructured and structured vcs
`timescale 1ns/1ps
`include "aal1_seg_defs.vh"

// Notes on behaviour
// - each unstructured port flags a full 47-byte block to the engine.
// - each block gets one header byte with sequence number and protection.
// - a 5-byte cell header (6 with 16-bit width) precedes each 48-byte payload, cell goes to transmit.
// - structured mode serves up to 256 vcs, channels from any port.
// - channel count per vc ranges 1 to 128.
// - per-vc count of octets still needed for next cell, starts at 47.
// - remainder flag set when this frame yields more than one cell.
// - wait flag holds first cell to multiframe boundary, sequence 0, pointer 0.
// - first-cell flag marks next cell as first; cleared for staggered start.
// - timestamp fetched at sequence 0, msb sent in odd cells, then shifted.
// - timestamp disabled gives zero csi in odd cells; one such vc per port.
// - mode 01 ds1 cas, 10 e1 cas, 11 e1 cas two channels, 00 other.
// - structure boundary pointer counts octets to next boundary, starts zero.
// - pointer-sent flag allows one pointer cell per eight-cell sequence.
// - pointer enable yields one pointer cell per sequence via next-is-pointer bit.
// - current tdm and cas indices pick the next base address, start 0Ah.
// - header fields copied out; udf2 sent only with 16-bit transmit width.
// - 20-bit read address is channel base address joined with read pointer.
// - no cells are built until the global enable is set.
module aal1_cbr_cell_segmenter (
    input  wire              clock_i,
    input  wire              sys_rst_i,
    input  wire              segmentation_global_enable_i,
    input  wire              utopia_16bit_i,
    input  wire [7:0]        block_full_i,
    input  wire              sdt_frame_i,
    input  wire [7:0]        sdt_vc_i,
    input  wire [2:0]        sdt_port_i,
    input  wire              sdt_multiframe_i,
    output wire              sdt_ready_o,
    input  wire [31:0]       rts_value_i,
    output reg               ext_req_o,
    output reg  [19:0]       ext_addr_o,
    input  wire              ext_ack_i,
    input  wire [7:0]        ext_data_i,
    input  wire              cfg_wr_i,
    input  wire [1:0]        cfg_sel_i,
    input  wire [10:0]       cfg_addr_i,
    input  wire [`ST_W-1:0]  cfg_wdata_i,
    output wire              cfg_ready_o,
    output reg  [`ST_W-1:0]  cfg_rdata_o,
    output wire [7:0]        cell_data_o,
    output wire              cell_sop_o,
    output wire              cell_valid_o,
    input  wire              cell_ready_i,
    output wire              engine_busy_o
);
    localparam S_IDLE = 3'h0;
    localparam S_EVAL = 3'h1;
    localparam S_HDR  = 3'h2;
    localparam S_SNB  = 3'h3;
    localparam S_PTR  = 3'h4;
    localparam S_RD   = 3'h5;
    localparam S_DONE = 3'h6;
    localparam S_WB   = 3'h7;

    reg [`ST_W-1:0]  st_mem   [0:`NUM_VC-1];
    reg [`HDR_W-1:0] hdr_mem  [0:`NUM_VC-1];
    reg [12:0]       base_mem [0:`NUM_BASE-1];

    reg [2:0]        state_reg;
    reg [`ST_W-1:0]  ws_reg;
    reg [`HDR_W-1:0] hw_reg;
    reg [7:0]        vc_reg;
    reg [2:0]        port_reg;
    reg              udt_reg;
    reg              mf_reg;
    reg              ptr_reg;
    reg [8:0]        left_reg;
    reg [5:0]        cnt_reg;
    reg [2:0]        hidx_reg;
    reg [7:0]        pend_reg;
    reg [7:0]        pend_clr;
    reg [2:0]        pick;
    reg              push_v;
    reg [8:0]        push_d;
    integer          i;

    wire             in_rdy;
    wire [5:0]       octets  = ws_reg[`OCT_P +: 6];
    wire [7:0]       nchan   = ws_reg[`NCH_P +: 8];
    wire [6:0]       rdptr   = ws_reg[`RDP_P +: 7];
    wire             wmf     = ws_reg[`WMF_P];
    wire             first   = ws_reg[`FST_P];
    wire [3:0]       srts    = ws_reg[`SRTS_P +: 4];
    wire [2:0]       sn      = ws_reg[`SN_P +: 3];
    wire             se      = ws_reg[`SE_P];
    wire             ps      = ws_reg[`PS_P];
    wire             pe      = ws_reg[`PE_P];
    wire             pn      = ws_reg[`PN_P];
    wire [1:0]       mode    = ws_reg[`MODE_P +: 2];
    wire [11:0]      sbp     = ws_reg[`SBP_P +: 12];
    wire [11:0]      slen    = ws_reg[`SLEN_P +: 12];
    wire [7:0]       ctdm    = ws_reg[`CTDM_P +: 8];
    wire [7:0]       ccas    = ws_reg[`CCAS_P +: 8];
    wire [7:0]       last    = ws_reg[`LAST_P +: 8];
    wire [6:0]       ncas    = ws_reg[`NCAS_P +: 7];
    wire [10:0]      bidx    = ws_reg[`BIDX_P +: 11];

    // mode 00 with no signalling octets is a plain payload vc
    wire             cas_vc  = (mode != 2'b00) || (ncas != 7'h00);
    wire             in_sig  = cas_vc && (sbp != 12'h000) && (sbp <= {5'h00, ncas});
    wire [7:0]       cur_idx = in_sig ? ccas : ctdm;
    wire [10:0]      ent     = udt_reg ? bidx : bidx + {3'h0, cur_idx} - {3'h0, `CBUF_FIRST};
    wire [6:0]       bofs    = udt_reg ? {1'b0, `PAYLOAD_LEN - cnt_reg} : rdptr;
    wire             isptr   = !udt_reg && pe && pn && !ps && !sn[0];
    wire [5:0]       need    = octets - {5'h00, isptr};
    wire [2:0]       hlast   = utopia_16bit_i ? `LAST_HDR16 : `LAST_HDR8;
    wire             csi     = sn[0] ? (se & srts[3]) : ptr_reg;
    wire [2:0]       crc     = crc3({csi, sn});
    wire [7:0]       sn_byte = {csi, sn, crc, ^{csi, sn, crc}};
    wire [6:0]       poff    = first ? 7'h00 : (sbp > `PTR_MAX) ? `NO_BOUNDARY : sbp[6:0];
    wire [7:0]       p_byte  = {^poff, poff};
    wire [7:0]       h_byte  = hw_reg[`HDR_W-1-8*hidx_reg -: 8];
    wire             rd_done = ext_req_o && ext_ack_i;

    function [2:0] crc3;
        input [3:0] d;
        reg   [2:0] r;
        integer     k;
        begin
            r = 3'h0;
            for (k = 3; k >= 0; k = k - 1) begin
                r = {r[1:0], 1'b0} ^ ((d[k] ^ r[2]) ? 3'h3 : 3'h0);
            end
            crc3 = r;
        end
    endfunction

    assign sdt_ready_o   = (state_reg == S_IDLE) && segmentation_global_enable_i
                           && (pend_reg == 8'h00);
    assign cfg_ready_o   = (state_reg == S_IDLE);
    assign engine_busy_o = (state_reg != S_IDLE);

    // lowest pending unstructured port first
    always @* begin
        pick = 3'h0;
        for (i = `NUM_PORT - 1; i >= 0; i = i - 1) begin
            if (pend_reg[i]) begin
                pick = i[2:0];
            end
        end
    end

    always @* begin
        push_v = 1'b0;
        push_d = 9'h000;
        case (state_reg)
            S_HDR: begin
                push_v = 1'b1;
                push_d = {hidx_reg == 3'h0, h_byte};
            end
            S_SNB: begin
                push_v = 1'b1;
                push_d = {1'b0, sn_byte};
            end
            S_PTR: begin
                push_v = 1'b1;
                push_d = {1'b0, p_byte};
            end
            S_RD: begin
                push_v = rd_done;
                push_d = {1'b0, ext_data_i};
            end
            default: begin
                push_v = 1'b0;
                push_d = 9'h000;
            end
        endcase
    end

    seg_byte_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (push_v),
        .in_ready_o  (in_rdy),
        .in_data_i   (push_d),
        .out_valid_o (cell_valid_o),
        .out_ready_i (cell_ready_i),
        .out_data_o  ({cell_sop_o, cell_data_o})
    );

    // memories: the engine writes back only in S_WB, software only when idle
    always @(posedge clock_i) begin
        if (state_reg == S_WB) begin
            st_mem[vc_reg] <= ws_reg;
        end else if (cfg_wr_i && (state_reg == S_IDLE)) begin
            case (cfg_sel_i)
                `SEL_HDR:  hdr_mem[cfg_addr_i[7:0]] <= cfg_wdata_i[`HDR_W-1:0];
                `SEL_ST:   st_mem[cfg_addr_i[7:0]]  <= cfg_wdata_i;
                `SEL_BASE: base_mem[cfg_addr_i]     <= cfg_wdata_i[12:0];
                default:   base_mem[cfg_addr_i]     <= base_mem[cfg_addr_i];
            endcase
        end
        cfg_rdata_o <= st_mem[cfg_addr_i[7:0]];
    end

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pend_reg <= 8'h00;
        end else begin
            pend_reg <= (pend_reg & ~pend_clr) | block_full_i;
        end
    end

    always @* begin
        pend_clr = 8'h00;
        if ((state_reg == S_IDLE) && segmentation_global_enable_i && (pend_reg != 8'h00)) begin
            pend_clr[pick] = 1'b1;
        end
    end

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg  <= S_IDLE;
            ws_reg     <= {`ST_W{1'b0}};
            hw_reg     <= {`HDR_W{1'b0}};
            vc_reg     <= 8'h00;
            port_reg   <= 3'h0;
            udt_reg    <= 1'b0;
            mf_reg     <= 1'b0;
            ptr_reg    <= 1'b0;
            left_reg   <= 9'h000;
            cnt_reg    <= 6'h00;
            hidx_reg   <= 3'h0;
            ext_req_o  <= 1'b0;
            ext_addr_o <= 20'h00000;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    hidx_reg <= 3'h0;
                    if (segmentation_global_enable_i && (pend_reg != 8'h00)) begin
                        vc_reg   <= {5'h00, pick};
                        port_reg <= pick;
                        udt_reg  <= 1'b1;
                        ptr_reg  <= 1'b0;
                        cnt_reg  <= `PAYLOAD_LEN;
                        ws_reg   <= st_mem[{5'h00, pick}];
                        hw_reg   <= hdr_mem[{5'h00, pick}];
                        state_reg <= S_HDR;
                    end else if (sdt_ready_o && sdt_frame_i) begin
                        vc_reg   <= sdt_vc_i;
                        port_reg <= sdt_port_i;
                        udt_reg  <= 1'b0;
                        mf_reg   <= sdt_multiframe_i;
                        ws_reg   <= st_mem[sdt_vc_i];
                        hw_reg   <= hdr_mem[sdt_vc_i];
                        left_reg <= {1'b0, st_mem[sdt_vc_i][`NCH_P +: 8]};
                        state_reg <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    hidx_reg <= 3'h0;
                    if (first && wmf && !mf_reg) begin
                        left_reg  <= 9'h000;
                        state_reg <= S_WB;
                    end else if (left_reg >= {3'h0, need}) begin
                        left_reg <= left_reg - {3'h0, need};
                        ws_reg[`RM_P] <= (left_reg >= {3'h0, need} + {3'h0, `PAYLOAD_LEN});
                        ptr_reg  <= isptr;
                        cnt_reg  <= need;
                        state_reg <= S_HDR;
                    end else begin
                        ws_reg[`OCT_P +: 6] <= octets - left_reg[5:0];
                        ws_reg[`RM_P]       <= 1'b0;
                        left_reg  <= 9'h000;
                        state_reg <= S_WB;
                    end
                end
                S_HDR: begin
                    if (in_rdy) begin
                        hidx_reg <= hidx_reg + 3'h1;
                        if (hidx_reg == hlast) begin
                            state_reg <= S_SNB;
                        end
                    end
                end
                S_SNB: begin
                    if (in_rdy) begin
                        if ((sn == 3'h0) && se) begin
                            ws_reg[`SRTS_P +: 4] <= rts_value_i[4*port_reg +: 4];
                        end
                        state_reg <= ptr_reg ? S_PTR : S_RD;
                    end
                end
                S_PTR: begin
                    if (in_rdy) begin
                        state_reg <= S_RD;
                    end
                end
                S_RD: begin
                    if (!ext_req_o && in_rdy) begin
                        ext_req_o  <= 1'b1;
                        ext_addr_o <= {base_mem[ent], bofs};
                    end else if (rd_done) begin
                        ext_req_o <= 1'b0;
                        cnt_reg   <= cnt_reg - 6'h01;
                        if (!udt_reg) begin
                            ws_reg[`SBP_P +: 12] <= (sbp == 12'h000) ? slen - 12'h001
                                                                     : sbp - 12'h001;
                            if (in_sig) begin
                                ws_reg[`CCAS_P +: 8] <= (ccas == last) ? `CBUF_FIRST
                                                                       : ccas + 8'h01;
                            end else if (ctdm == last) begin
                                ws_reg[`CTDM_P +: 8] <= `CBUF_FIRST;
                                ws_reg[`RDP_P +: 7]  <= rdptr + 7'h01;
                            end else begin
                                ws_reg[`CTDM_P +: 8] <= ctdm + 8'h01;
                            end
                        end
                        if (cnt_reg == 6'h01) begin
                            state_reg <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    ws_reg[`SN_P +: 3]   <= sn + 3'h1;
                    ws_reg[`FST_P]       <= 1'b0;
                    ws_reg[`OCT_P +: 6]  <= `PAYLOAD_LEN;
                    ws_reg[`CNT_P +: 16] <= ws_reg[`CNT_P +: 16] + 16'h0001;
                    if (sn[0]) begin
                        ws_reg[`SRTS_P +: 4] <= se ? {srts[2:0], 1'b0} : 4'h0;
                    end
                    if (sn == 3'h7) begin
                        ws_reg[`PS_P] <= 1'b0;
                        ws_reg[`PN_P] <= pe;
                    end else if (ptr_reg) begin
                        ws_reg[`PS_P] <= 1'b1;
                        ws_reg[`PN_P] <= 1'b0;
                    end
                    state_reg <= udt_reg ? S_WB : S_EVAL;
                end
                S_WB: begin
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end
endmodule // aal1_cbr_cell_segmenter

// *** verification/aal1_seg_monitor.sv ***
// port checker for the cbr cell segmenter
`timescale 1ns/1ps
module aal1_seg_monitor (
    input logic        clock_i,
    input logic        sys_rst_i,
    input logic        segmentation_global_enable_i,
    input logic        utopia_16bit_i,
    input logic [7:0]  block_full_i,
    input logic        sdt_ready_o,
    input logic        ext_req_o,
    input logic [19:0] ext_addr_o,
    input logic        ext_ack_i,
    input logic        cfg_ready_o,
    input logic [7:0]  cell_data_o,
    input logic        cell_sop_o,
    input logic        cell_valid_o,
    input logic        cell_ready_i,
    input logic        engine_busy_o
);
    logic [5:0] bcnt_reg;
    wire        take      = cell_valid_o && cell_ready_i;
    wire  [5:0] bcnt_next = cell_sop_o ? 6'h01 : bcnt_reg + 6'h01;
    wire  [5:0] cell_len  = utopia_16bit_i ? 6'h36 : 6'h35;

    // position of the accepted byte inside its cell
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) bcnt_reg <= 6'h00;
        else if (take && (bcnt_next == cell_len)) bcnt_reg <= 6'h00;
        else if (take) bcnt_reg <= bcnt_next;
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_block_taken;
        segmentation_global_enable_i && cfg_ready_o && (block_full_i != 8'h00);
    endsequence
    sequence s_busy_soon;
        ##[1:4] engine_busy_o;
    endsequence

    chk_block_starts_cell: assert property (s_block_taken |-> s_busy_soon)
        else $error("full block did not start the engine");
    chk_idle_when_off: assert property (!segmentation_global_enable_i && !engine_busy_o
        |=> !engine_busy_o)
        else $error("engine started while disabled");
    chk_frame_gate: assert property (sdt_ready_o |-> segmentation_global_enable_i
        && cfg_ready_o)
        else $error("frame accepted while disabled or busy");
    chk_read_held: assert property (ext_req_o && !ext_ack_i |=> ext_req_o
        && $stable(ext_addr_o))
        else $error("read request dropped or address moved");
    chk_one_read: assert property (ext_ack_i |=> !ext_req_o)
        else $error("request not released after answer");
    chk_cell_held: assert property (cell_valid_o && !cell_ready_i |=> cell_valid_o
        && $stable(cell_data_o) && $stable(cell_sop_o))
        else $error("cell byte changed while stalled");
    chk_sop_first: assert property (take && cell_sop_o |-> bcnt_reg == 6'h00)
        else $error("start of cell inside a cell");
    chk_sop_missing: assert property (take && !cell_sop_o |-> bcnt_reg != 6'h00)
        else $error("cell began without start marker");
endmodule // aal1_seg_monitor

bind aal1_cbr_cell_segmenter aal1_seg_monitor mon_u (.clock_i, .sys_rst_i,
    .segmentation_global_enable_i, .utopia_16bit_i, .block_full_i, .sdt_ready_o, .ext_req_o,
    .ext_addr_o, .ext_ack_i, .cfg_ready_o, .cell_data_o, .cell_sop_o, .cell_valid_o,
    .cell_ready_i, .engine_busy_o);

// *** verification/cell_path_partner.sv ***
// far side model: external byte memory and cell transmit sink
`timescale 1ns/1ps
module cell_path_partner (
    input  wire        clock_i,
    input  wire        sys_rst_i,
    input  wire        slow_i,
    input  wire        ext_req_i,
    input  wire [19:0] ext_addr_i,
    output reg         ext_ack_o,
    output wire [7:0]  ext_data_o,
    input  wire [7:0]  cell_data_i,
    input  wire        cell_sop_i,
    input  wire        cell_valid_i,
    output reg         cell_ready_o
);
    reg [7:0] rd_reg;
    reg [1:0] wait_reg;
    reg [3:0] cyc_reg;
    reg [8:0] cap_data [0:1023];
    integer   cap_n;

    // released data bus shows the inverse of the last byte
    assign ext_data_o = ext_ack_o ? rd_reg : ~rd_reg;

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ext_ack_o    <= 1'b0;
            wait_reg     <= 2'h0;
            rd_reg       <= 8'h00;
            cyc_reg      <= 4'h0;
            cell_ready_o <= 1'b0;
            cap_n        <= 0;
        end else begin
            cyc_reg      <= cyc_reg + 4'h1;
            cell_ready_o <= !slow_i || (cyc_reg[1:0] == 2'h3);
            if (cell_valid_i && cell_ready_o) begin
                cap_data[cap_n] <= {cell_sop_i, cell_data_i};
                cap_n           <= cap_n + 1;
            end
            if (ext_ack_o) begin
                ext_ack_o <= 1'b0;
                wait_reg  <= 2'h0;
            end else if (ext_req_i && (wait_reg == (slow_i ? 2'h3 : 2'h0))) begin
                ext_ack_o <= 1'b1;
                rd_reg    <= ext_addr_i[7:0] ^ 8'h5A;
            end else if (ext_req_i) begin
                wait_reg  <= wait_reg + 2'h1;
            end
        end
    end
endmodule // cell_path_partner

// *** verification/test_aal1_cbr_cell_segmenter.sv ***
// self-checking bench for the cbr cell segmenter
`timescale 1ns/1ps
`include "aal1_seg_defs.vh"
module test_aal1_cbr_cell_segmenter;
    localparam [47:0] HDR  = 48'h1234_5678_9ABC;
    localparam [12:0] BASE = 13'h1A5;
    reg              clock_i, sys_rst_i, segmentation_global_enable_i, utopia_16bit_i;
    reg  [7:0]       block_full_i;
    reg              cfg_wr_i, slow, sdt_frame;
    reg  [1:0]       cfg_sel_i;
    reg  [10:0]      cfg_addr_i;
    reg  [`ST_W-1:0] cfg_wdata_i, st;
    wire             sdt_ready_o, ext_req_o, ext_ack_i, cfg_ready_o, cell_ready_i;
    wire [19:0]      ext_addr_o;
    wire [7:0]       ext_data_i, cell_data_o;
    wire [`ST_W-1:0] cfg_rdata_o;
    wire             cell_sop_o, cell_valid_o, engine_busy_o;
    integer          err_total, cmp_count, first, i;

    aal1_cbr_cell_segmenter dut_u (.clock_i, .sys_rst_i, .segmentation_global_enable_i,
        .utopia_16bit_i, .block_full_i, .sdt_frame_i(sdt_frame), .sdt_vc_i(8'h00),
        .sdt_port_i(3'h0), .sdt_multiframe_i(1'b0), .sdt_ready_o,
        .rts_value_i(32'h0000_0000), .ext_req_o, .ext_addr_o, .ext_ack_i, .ext_data_i,
        .cfg_wr_i, .cfg_sel_i, .cfg_addr_i, .cfg_wdata_i, .cfg_ready_o, .cfg_rdata_o,
        .cell_data_o, .cell_sop_o, .cell_valid_o, .cell_ready_i, .engine_busy_o);

    cell_path_partner partner_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .slow_i(slow),
        .ext_req_i(ext_req_o), .ext_addr_i(ext_addr_o), .ext_ack_o(ext_ack_i),
        .ext_data_o(ext_data_i), .cell_data_i(cell_data_o), .cell_sop_i(cell_sop_o),
        .cell_valid_i(cell_valid_o), .cell_ready_o(cell_ready_i));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask

    task check(input logic [127:0] seen, input logic [127:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
            end
        end
    endtask

    task tick(input integer n);
        begin
            repeat (n) @(posedge clock_i);
            #1;
        end
    endtask

    task timeout_fail;
        begin
            err_total = err_total + 1;
            $display("wait limit reached at %0t", $time);
            report_and_stop;
        end
    endtask

    task cfg_write(input [1:0] sel, input [10:0] addr, input [`ST_W-1:0] data);
        integer t;
        begin
            t = 0;
            while (cfg_ready_o !== 1'b1 && t < 200) begin
                tick(1);
                t = t + 1;
            end
            if (t == 200) timeout_fail;
            cfg_sel_i   = sel;
            cfg_addr_i  = addr;
            cfg_wdata_i = data;
            cfg_wr_i    = 1'b1;
            tick(1);
            cfg_wr_i    = 1'b0;
            tick(1);
        end
    endtask

    task pulse_block;
        begin
            block_full_i = 8'h04;
            tick(1);
            block_full_i = 8'h00;
        end
    endtask

    // sequence-number byte: csi, count, 3-bit crc, even parity
    function automatic [7:0] sn_byte(input [2:0] sn);
        reg [2:0] c;
        reg       fb;
        integer   b;
        begin
            c = 3'h0;
            for (b = 2; b >= 0; b = b - 1) begin
                fb = sn[b] ^ c[2];
                c = {c[1], c[0] ^ fb, fb};
            end
            sn_byte = {1'b0, sn, c, ^{sn, c}};
        end
    endfunction

    task expect_cell(input [2:0] sn);
        integer t, j, hl;
        reg [8:0] exp;
        begin
            hl = utopia_16bit_i ? 6 : 5;
            t = 0;
            while (partner_u.cap_n < first + hl + 48 && t < 3000) begin
                tick(1);
                t = t + 1;
            end
            if (t == 3000) timeout_fail;
            for (j = 0; j < hl + 48; j = j + 1) begin
                if (j < hl) exp = {j == 0, HDR[47 - 8*j -: 8]};
                else if (j == hl) exp = {1'b0, sn_byte(sn)};
                else exp = {1'b0, {BASE[0], 7'(j - hl - 1)} ^ 8'h5A};
                check(partner_u.cap_data[first + j], exp);
            end
            first = first + hl + 48;
            tick(10);
        end
    endtask

    initial begin
        #5000000;
        timeout_fail;
    end

    initial begin
        err_total = 0;
        cmp_count = 0;
        first = 0;
        sys_rst_i = 1'b1;
        segmentation_global_enable_i = 1'b0;
        utopia_16bit_i = 1'b0;
        block_full_i = 8'h00;
        cfg_wr_i = 1'b0;
        cfg_sel_i = 2'h0;
        cfg_addr_i = 11'h000;
        cfg_wdata_i = '0;
        slow = 1'b0;
        sdt_frame = 1'b0;
        repeat (20) @(posedge clock_i);
        #1 sys_rst_i = 1'b0;
        check(cell_valid_o, 1'b0);
        check(sdt_ready_o, 1'b0);
        st = '0;
        st[`OCT_P +: 6] = `PAYLOAD_LEN;
        st[`NCH_P +: 8] = 8'h01;
        st[`SLEN_P] = 1'b1;
        st[`CTDM_P +: 8] = `CBUF_FIRST;
        st[`CCAS_P +: 8] = `CBUF_FIRST;
        st[`LAST_P +: 8] = 8'h0A;
        st[`BIDX_P +: 11] = 11'h005;
        cfg_write(`SEL_HDR, 11'h002, {71'h0, HDR});
        cfg_write(`SEL_BASE, 11'h005, {106'h0, BASE});
        cfg_write(`SEL_ST, 11'h002, st);
        tick(2);
        check(cfg_rdata_o, st);
        pulse_block;
        tick(20);
        check(engine_busy_o, 1'b0);
        check(partner_u.cap_n, 0);
        segmentation_global_enable_i = 1'b1;
        // ten cells wrap the sequence count, alternating width each cell and stalling every second pair
        for (i = 0; i < 10; i = i + 1) begin
            utopia_16bit_i = i[0];
            slow = i[1];
            if (i > 0) pulse_block;
            expect_cell(i[2:0]);
        end
        tick(2);
        check(cfg_rdata_o[`SN_P +: 3], 3'h2);
        st[`FST_P -: 2] = 2'h3;
        cfg_write(`SEL_ST, 11'h000, st);
        check(sdt_ready_o, 1'b1);
        sdt_frame = 1'b1;
        tick(1);
        sdt_frame = 1'b0;
        tick(8);
        check(cfg_rdata_o[`OCT_P +: 6], `PAYLOAD_LEN);
        report_and_stop;
    end
endmodule // test_aal1_cbr_cell_segmenter
